/* File: rtl/arx_pkg.sv */
package arx_pkg;
  // Samples per bit in each speed mode
  localparam logic [4:0] ARX_SPB_NORMAL = 5'h10;
  localparam logic [4:0] ARX_SPB_DOUBLE = 5'h08;
  // Start-check and centre vote sample numbers (first and last; the middle one lies between)
  localparam logic [4:0] ARX_VOTE_N0    = 5'h08;
  localparam logic [4:0] ARX_VOTE_N2    = 5'h0a;
  localparam logic [4:0] ARX_VOTE_D0    = 5'h04;
  localparam logic [4:0] ARX_VOTE_D2    = 5'h06;
  // Data plus parity bit count limits
  localparam logic [3:0] ARX_BITS_MIN   = 4'h5;
  localparam logic [3:0] ARX_BITS_MAX   = 4'ha;
  localparam int         ARX_SYNC_LEN   = 3;

  typedef enum {ARX_IDLE, ARX_START, ARX_DATA, ARX_STOP} arx_state_t;

  typedef struct packed {
    logic [9:0] data;
    logic       frame_error;
  } arx_frame_t;
endpackage

/* File: rtl/arx_recovery.sv */
`timescale 1ns/10ps
module arx_recovery
  import arx_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        SERIAL_RX_PIN,
  input  wire logic        SAMPLE_TICK,
  input  wire logic        DOUBLE_SPEED_SELECT,
  input  wire logic        RECEIVER_ENABLE_BIT,
  input  wire logic [3:0]  FRAME_BITS,
  output logic             FRAME_VALID,
  output logic [9:0]       FRAME_DATA,
  output logic             FRAME_ERROR_FLAG,
  output logic             BUSY
);
  arx_state_t state_q;
  arx_state_t state_d;
  logic       rx_sync;
  logic       rx_prev_q;
  logic [4:0] samp_q;
  logic [4:0] samp_d;
  logic [3:0] bit_q;
  logic [2:0] vote_q;
  logic [9:0] shift_q;
  arx_frame_t frame_q;
  logic       valid_q;

  // Three-stage synchroniser ahead of all sampling
  arx_sync u_sync (
    .SYS_CLK  (SYS_CLK),
    .RESET    (RESET),
    .async_in (SERIAL_RX_PIN),
    .sync_out (rx_sync)
  );

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  wire        dbl       = DOUBLE_SPEED_SELECT;
  wire [4:0]  spb       = dbl ? ARX_SPB_DOUBLE : ARX_SPB_NORMAL;
  wire [4:0]  vote_lo   = dbl ? ARX_VOTE_D0 : ARX_VOTE_N0;
  wire [4:0]  vote_hi   = dbl ? ARX_VOTE_D2 : ARX_VOTE_N2;
  wire        in_vote   = (samp_q >= vote_lo) && (samp_q <= vote_hi);
  wire        last_vote = (samp_q == vote_hi);
  wire        bit_end   = (samp_q == spb);
  wire        fall      = rx_prev_q & ~rx_sync;
  // Frame width clamped into the supported range
  wire [3:0]  nbits     = (FRAME_BITS < ARX_BITS_MIN) ? ARX_BITS_MIN :
                          (FRAME_BITS > ARX_BITS_MAX) ? ARX_BITS_MAX : FRAME_BITS;
  wire        voted     = majority({vote_q[1:0], rx_sync});

  always_comb begin
    state_d = state_q;
    samp_d  = samp_q;
    if (SAMPLE_TICK) begin
      samp_d = bit_end ? 5'h01 : samp_q + 5'h01;
      case (state_q)
        ARX_IDLE: begin
          if (fall) begin
            state_d = ARX_START;
            samp_d  = 5'h02;
          end
        end
        ARX_START: begin
          if (last_vote) begin
            state_d = voted ? ARX_IDLE : ARX_DATA;
          end
        end
        ARX_DATA: begin
          // Stop follows once every data and parity bit has been captured
          if (bit_end && bit_q == nbits) begin
            state_d = ARX_STOP;
          end
        end
        ARX_STOP: begin
          // Back to edge search straight after the last vote sample
          if (last_vote) begin
            state_d = ARX_IDLE;
          end
        end
        default: state_d = ARX_IDLE;
      endcase
    end
  end

  // Sample counter is the per-bit state; it restarts on each start edge
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !RECEIVER_ENABLE_BIT) begin
      state_q <= ARX_IDLE;
      samp_q  <= 5'h00;
    end else begin
      state_q <= state_d;
      samp_q  <= (state_d == ARX_IDLE) ? 5'h00 : samp_d;
    end
  end

  // Previous line level only tracked on ticks, so edges are seen per sample
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rx_prev_q <= 1'b1;
    end else if (SAMPLE_TICK) begin
      rx_prev_q <= rx_sync;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET || state_q == ARX_IDLE) begin
      vote_q <= 3'h0;
    end else if (SAMPLE_TICK && in_vote) begin
      vote_q <= {vote_q[1:0], rx_sync};
    end
  end

  // Counted at each capture, so the tail of the start bit is never taken for a data bit
  always_ff @(posedge SYS_CLK) begin
    if (RESET || state_q != ARX_DATA) begin
      bit_q <= 4'h0;
    end else if (SAMPLE_TICK && last_vote) begin
      bit_q <= bit_q + 4'h1;
    end
  end

  // LSB first; each bit is written straight to its index bit_q, so no justification at frame end
  always_ff @(posedge SYS_CLK) begin
    if (RESET || state_q == ARX_IDLE) begin
      shift_q <= 10'h000;
    end else if (SAMPLE_TICK && state_q == ARX_DATA && last_vote) begin
      shift_q[bit_q] <= voted;
    end
  end

  // Error flag held with its frame until the next frame replaces it or reset or a dropped enable clears it
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !RECEIVER_ENABLE_BIT) begin
      valid_q <= 1'b0;
      frame_q <= '0;
    end else begin
      valid_q <= 1'b0;
      if (SAMPLE_TICK && state_q == ARX_STOP && last_vote) begin
        valid_q             <= 1'b1;
        frame_q.data        <= shift_q;
        frame_q.frame_error <= ~voted;
      end
    end
  end

  assign FRAME_VALID      = valid_q;
  assign FRAME_DATA       = frame_q.data;
  assign FRAME_ERROR_FLAG = frame_q.frame_error;
  assign BUSY             = (state_q != ARX_IDLE);

  stop_err_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SAMPLE_TICK && state_q == ARX_STOP && last_vote && RECEIVER_ENABLE_BIT)
    |=> (FRAME_VALID && FRAME_ERROR_FLAG == !$past(voted)))
    else $error("frame error not from stop vote");
  start_reject_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SAMPLE_TICK && state_q == ARX_START && last_vote && voted) |=> state_q == ARX_IDLE)
    else $error("noisy start not rejected");
  start_accept_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SAMPLE_TICK && state_q == ARX_START && last_vote && !voted && RECEIVER_ENABLE_BIT)
    |=> state_q == ARX_DATA)
    else $error("valid start not taken");
  disable_stop_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !RECEIVER_ENABLE_BIT |=> (!BUSY && !FRAME_VALID))
    else $error("receiver not stopped");
  samp_range_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    samp_q <= spb)
    else $error("sample state out of range");
  edge_start_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SAMPLE_TICK && state_q == ARX_IDLE && fall && RECEIVER_ENABLE_BIT)
    |=> (state_q == ARX_START && samp_q == 5'h02))
    else $error("start edge missed");
  stop_idle_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    FRAME_VALID |-> state_q == ARX_IDLE)
    else $error("not idle after stop vote");
  bit_count_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    bit_q <= ARX_BITS_MAX)
    else $error("bit count overrun");

  // Frame, bit and sample checks; the stop bit may only follow the last data or parity bit
  valid_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    FRAME_VALID |=> !FRAME_VALID)
    else $error("frame valid longer than one cycle");
  data_vote_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SAMPLE_TICK && state_q == ARX_DATA && last_vote && RECEIVER_ENABLE_BIT)
    |=> (shift_q[$past(bit_q)] == $past(voted)))
    else $error("data bit not taken from vote");
  stop_entry_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_q == ARX_STOP && $past(state_q) == ARX_DATA)
    |-> ($past(bit_q) == nbits))
    else $error("stop bit taken before last data bit");
  upper_zero_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    FRAME_VALID |-> ((FRAME_DATA >> nbits) == 10'h000))
    else $error("unused data bits not zero");
  start_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_q == ARX_START)
    |-> (bit_q == 4'h0 && shift_q == 10'h000))
    else $error("frame state not cleared at start");
  idle_samp_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_q == ARX_IDLE) |-> (samp_q == 5'h00))
    else $error("sample state not cleared in idle");
  tick_hold_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!SAMPLE_TICK && RECEIVER_ENABLE_BIT)
    |=> ($stable(samp_q) && $stable(state_q)))
    else $error("state moved without a sample tick");
  stop_return_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SAMPLE_TICK && state_q == ARX_STOP && last_vote && RECEIVER_ENABLE_BIT)
    |=> (state_q == ARX_IDLE && rx_prev_q == $past(rx_sync)))
    else $error("edge search not resumed after stop vote");
endmodule

/* File: rtl/arx_sync.sv */
`timescale 1ns/10ps
module arx_sync
  import arx_pkg::*;
(
  input  wire logic SYS_CLK,
  input  wire logic RESET,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [ARX_SYNC_LEN-1:0] stage_q;

  // Idle line is high, so stages reset high
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stage_q <= '1;
    end else begin
      stage_q <= {stage_q[ARX_SYNC_LEN-2:0], async_in};
    end
  end

  // Stage 0 only feeds stage 1; a change counts once stages 1 and 2 agree
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sync_out <= 1'b1;
    end else if (stage_q[1] == stage_q[2]) begin
      sync_out <= stage_q[2];
    end
  end
endmodule

/* File: test/arx_tx_model.sv */
`timescale 1ns/10ps
module arx_tx_model (
  input  wire logic SYS_CLK,
  input  wire logic tick,
  output logic      line
);
  initial line = 1'b1;
  // Bit edges follow the same tick, so the rate error is zero
  task automatic wait_ticks(input int k);
    repeat (k) begin
      @(posedge SYS_CLK);
      while (tick !== 1'b1) @(posedge SYS_CLK);
    end
    #1;
  endtask
  // Start, n bits LSB first, a stop bit of stl ticks, then idl ticks of idle high
  task automatic send(input logic [9:0] d, input int n, input logic stp, input int spb,
                      input int stl, input int idl);
    for (int i = 0; i <= n; i++) begin
      line = (i == 0) ? 1'b0 : d[i-1];
      wait_ticks(spb);
    end
    line = stp;
    wait_ticks(stl);
    if (idl > 0) begin
      line = 1'b1;
      wait_ticks(idl);
    end
  endtask
  task automatic glitch(input int g, input int spb);
    line = 1'b0;
    wait_ticks(g);
    line = 1'b1;
    wait_ticks(3 * spb);
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import arx_pkg::*;
;
  logic       SYS_CLK, RESET, tick, en, dbl, line, fv, fe, busy;
  logic [3:0] fbits;
  logic [9:0] fdata;
  logic [1:0] tcnt;
  logic [31:0] seed;
  logic [9:0] d;
  int         fail_count, checks_done, cyc, spb, nb, vh;
  arx_frame_t exp_q[$];
  arx_frame_t e;

  arx_recovery u_dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .SERIAL_RX_PIN(line),
    .SAMPLE_TICK(tick), .DOUBLE_SPEED_SELECT(dbl), .RECEIVER_ENABLE_BIT(en),
    .FRAME_BITS(fbits), .FRAME_VALID(fv), .FRAME_DATA(fdata),
    .FRAME_ERROR_FLAG(fe), .BUSY(busy));
  arx_tx_model u_tx (.SYS_CLK(SYS_CLK), .tick(tick), .line(line));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  // Tick every fourth clock keeps frames short
  initial begin
    tick = 1'b0;
    tcnt = 2'h0;
  end
  always @(posedge SYS_CLK) begin
    tcnt <= tcnt + 2'h1;
    tick <= #1 (tcnt == 2'h3);
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  // Every pulse must match the oldest frame sent
  always @(posedge SYS_CLK) begin
    if (fv === 1'b1) begin
      cmp1(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        cmp10(fdata, e.data);
        cmp1(fe, e.frame_error);
      end
    end
  end

  initial begin
    RESET = 1'b1;
    en = 1'b1;
    dbl = 1'b0;
    fbits = 4'h8;
    seed = 32'h5f60;
    repeat (3) @(posedge SYS_CLK);
    #1 RESET = 1'b0;
    repeat (12) @(posedge SYS_CLK);
    for (int m = 0; m < 2; m++) begin
      dbl = m[0];
      spb = m ? int'(ARX_SPB_DOUBLE) : int'(ARX_SPB_NORMAL);
      u_tx.glitch(spb / 2 - 1, spb);
      for (int n = 5; n <= 10; n++) begin
        for (int r = 0; r < 2; r++) begin
          seed = lfsr(seed);
          d = seed[9:0] & ((10'h001 << n) - 10'h001);
          fbits = n[3:0];
          exp_q.push_back('{data: d, frame_error: r[0]});
          u_tx.send(seed[9:0], n, ~r[0], spb, spb, 2 * spb);
        end
      end
      // Shortest stop bit, the next start right behind it for even k; out-of-range widths clamp
      vh = m ? int'(ARX_VOTE_D2) : int'(ARX_VOTE_N2);
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        nb = k[1] ? 5 : 10;
        fbits = k[1] ? 4'h2 : 4'hf;
        d = seed[9:0] & ((10'h001 << nb) - 10'h001);
        exp_q.push_back('{data: d, frame_error: 1'b0});
        u_tx.send(seed[9:0], nb, 1'b1, spb, vh, k[0] ? 2 * spb : 0);
      end
    end
    // Drop the enable in mid-frame; nothing may come out
    fork
      u_tx.send(10'h2a5, 8, 1'b1, spb, spb, 2 * spb);
      begin
        repeat (60) @(posedge SYS_CLK);
        #1 en = 1'b0;
      end
    join
    cmp10(fdata, 10'h000);
    cmp1(busy, 1'b0);
    en = 1'b1;
    repeat (20) @(posedge SYS_CLK);
    cmp1(exp_q.size() == 0, 1'b1);
    stop_test();
  end
endmodule
